// ### amm_pkg.sv
package amm_pkg;

  // Widths
  localparam int SMP_W = 16;
  localparam int CH_W  = 3;
  localparam int MAP_W = 3;

  typedef logic [SMP_W-1:0] amm_code_t;

  // Converter sample strobe with channel and code
  typedef struct packed {
    logic             valid;
    logic [CH_W-1:0]  chan;
    amm_code_t        data;
  } amm_smp_t;

  typedef enum logic [1:0] {
    AMM_DIS   = 2'h0,
    AMM_LATCH = 2'h1,
    AMM_MOM   = 2'h2
  } amm_mode_t;

  // Per-channel alarm configuration word, top bit downward
  typedef struct packed {
    logic [MAP_W-1:0] lo_map;
    logic             lo_map_en;
    amm_mode_t        lo_mode;
    logic [MAP_W-1:0] hi_map;
    logic             hi_map_en;
    amm_mode_t        hi_mode;
  } amm_cfg_t;

  localparam int CFG_W = 12;

  // Global register byte offsets
  localparam logic [11:0] OFS_ALM_STAT  = 12'h000;
  localparam logic [11:0] OFS_LATCH_CLR = 12'h004;
  localparam logic [11:0] OFS_REC_RST   = 12'h008;
  localparam logic [11:0] OFS_OVR       = 12'h00c;
  localparam logic [11:0] OFS_IRQ_STAT  = 12'h010;
  localparam logic [11:0] OFS_IRQ_MASK  = 12'h014;
  localparam logic [11:0] OFS_RNG_LO    = 12'h018;
  localparam logic [11:0] OFS_RNG_HI    = 12'h01c;
  localparam logic [11:0] OFS_DO        = 12'h020;

  // Channel blocks: base page, 32-byte stride, word index inside
  localparam logic [3:0] PAGE_GLOBAL = 4'h0;
  localparam logic [3:0] PAGE_CHAN   = 4'h1;
  localparam logic [2:0] CH_HI_LIM   = 3'h0;
  localparam logic [2:0] CH_LO_LIM   = 3'h1;
  localparam logic [2:0] CH_CFG      = 3'h2;
  localparam logic [2:0] CH_MAX      = 3'h3;
  localparam logic [2:0] CH_MIN      = 3'h4;
  localparam logic [2:0] CH_CUR      = 3'h5;

  // Field positions (low-alarm group, over-range group, over-range bit of the current word) and interrupt width
  localparam int FLD_LO      = 8;
  localparam int FLD_OVR     = 16;
  localparam int FLD_CUR_OVR = 31;
  localparam int IRQ_W       = 24;

  // Reset values
  localparam amm_code_t RST_HI_LIM = 16'hffff;
  localparam amm_code_t RST_LO_LIM = 16'h0000;
  localparam amm_code_t RST_RNG_LO = 16'h0000;
  localparam amm_code_t RST_RNG_HI = 16'hffff;
  localparam amm_code_t CODE_LOW   = 16'h0000;
  localparam amm_code_t CODE_HIGH  = 16'hffff;

endpackage

// ### amm_monitor.sv
`timescale 1ns/1ps
module amm_monitor #(
  parameter int NCH = 8,
  parameter int NDO = 8
) (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RST_N,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Converter samples, same clock
  input  wire amm_pkg::amm_smp_t SMP,
  // Alarm and range status
  output logic      [NCH-1:0]    ALM_HI,
  output logic      [NCH-1:0]    ALM_LO,
  output logic      [NCH-1:0]    OVR,
  // Digital outputs and interrupt
  output logic      [NDO-1:0]    DO_OUT,
  output logic                   IRQ
);
  import amm_pkg::*;

  logic                 pready_ff;
  logic [31:0]          prdata_ff;
  logic                 pslverr_ff;
  logic [31:0]          rd_data;
  logic                 rd_ok;
  logic                 wr_en;
  logic                 rd_cap;
  logic                 is_glob;
  logic                 is_chan;
  logic [2:0]           ch_idx;
  logic [2:0]           ch_reg;

  amm_code_t            hi_lim_ff [NCH];
  amm_code_t            lo_lim_ff [NCH];
  amm_code_t            max_ff    [NCH];
  amm_code_t            min_ff    [NCH];
  amm_code_t            cur_ff    [NCH];
  amm_cfg_t             cfg_ff    [NCH];
  logic [NCH-1:0]       alm_hi_ff;
  logic [NCH-1:0]       alm_lo_ff;
  logic [NCH-1:0]       ovr_ff;
  logic [NCH-1:0]       ev_hi;
  logic [NCH-1:0]       ev_lo;
  logic [NCH-1:0]       ev_ovr;
  logic [NCH-1:0]       clr_hi;
  logic [NCH-1:0]       clr_lo;
  logic [NCH-1:0]       rst_max;
  logic [NCH-1:0]       rst_min;
  amm_code_t            rng_lo_ff;
  amm_code_t            rng_hi_ff;
  logic [IRQ_W-1:0]     irq_stat_ff;
  logic [IRQ_W-1:0]     irq_mask_ff;
  logic [IRQ_W-1:0]     irq_ev;
  logic [IRQ_W-1:0]     irq_clr;
  logic [IRQ_W-1:0]     nxt_irq_stat;
  logic                 irq_ff;
  logic [NDO-1:0]       do_ff;
  logic [NDO-1:0]       nxt_do;

  // Bus decode; one wait state so read data comes from a flop
  assign wr_en   = PSEL & PENABLE & PWRITE & pready_ff;
  assign rd_cap  = PSEL & PENABLE & ~pready_ff;
  assign is_glob = PADDR[11:8] == PAGE_GLOBAL;
  assign is_chan = (PADDR[11:8] == PAGE_CHAN) && (32'(PADDR[7:5]) < NCH);
  assign ch_idx  = PADDR[7:5];
  assign ch_reg  = PADDR[4:2];

  // Write-one command pulses, live only in the write cycle
  assign clr_hi  = (wr_en && is_glob && PADDR[7:0] == OFS_LATCH_CLR[7:0]) ? PWDATA[NCH-1:0] : '0;
  assign clr_lo  = (wr_en && is_glob && PADDR[7:0] == OFS_LATCH_CLR[7:0]) ?
                   PWDATA[FLD_LO+NCH-1:FLD_LO] : '0;
  assign rst_max = (wr_en && is_glob && PADDR[7:0] == OFS_REC_RST[7:0]) ? PWDATA[NCH-1:0] : '0;
  assign rst_min = (wr_en && is_glob && PADDR[7:0] == OFS_REC_RST[7:0]) ?
                   PWDATA[FLD_LO+NCH-1:FLD_LO] : '0;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= rd_cap;
      pslverr_ff <= rd_cap & ~rd_ok;
      if (rd_cap) begin
        prdata_ff <= PWRITE ? 32'h0000_0000 : rd_data;
      end
    end
  end

  // Read mux; also decides whether the address is mapped
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (is_glob) begin
      unique case (PADDR[7:0])
        OFS_ALM_STAT[7:0]: begin
          rd_data[NCH-1:0]               = alm_hi_ff;
          rd_data[FLD_LO+NCH-1:FLD_LO]   = alm_lo_ff;
        end
        OFS_LATCH_CLR[7:0], OFS_REC_RST[7:0]: rd_data = 32'h0000_0000;
        OFS_OVR[7:0]:      rd_data[NCH-1:0]   = ovr_ff;
        OFS_IRQ_STAT[7:0]: rd_data[IRQ_W-1:0] = irq_stat_ff;
        OFS_IRQ_MASK[7:0]: rd_data[IRQ_W-1:0] = irq_mask_ff;
        OFS_RNG_LO[7:0]:   rd_data[SMP_W-1:0] = rng_lo_ff;
        OFS_RNG_HI[7:0]:   rd_data[SMP_W-1:0] = rng_hi_ff;
        OFS_DO[7:0]:       rd_data[NDO-1:0]   = do_ff;
        default:           rd_ok = 1'b0;
      endcase
    end else if (is_chan) begin
      unique case (ch_reg)
        CH_HI_LIM: rd_data[SMP_W-1:0] = hi_lim_ff[ch_idx];
        CH_LO_LIM: rd_data[SMP_W-1:0] = lo_lim_ff[ch_idx];
        CH_CFG:    rd_data[CFG_W-1:0] = cfg_ff[ch_idx];
        CH_MAX:    rd_data[SMP_W-1:0] = max_ff[ch_idx];
        CH_MIN:    rd_data[SMP_W-1:0] = min_ff[ch_idx];
        CH_CUR: begin
          rd_data[SMP_W-1:0]  = cur_ff[ch_idx];
          rd_data[FLD_CUR_OVR] = ovr_ff[ch_idx];
        end
        default:   rd_ok = 1'b0;
      endcase
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Global configuration
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rng_lo_ff   <= RST_RNG_LO;
      rng_hi_ff   <= RST_RNG_HI;
      irq_mask_ff <= '0;
    end else if (wr_en && is_glob) begin
      if (PADDR[7:0] == OFS_RNG_LO[7:0]) begin
        rng_lo_ff <= PWDATA[SMP_W-1:0];
      end
      if (PADDR[7:0] == OFS_RNG_HI[7:0]) begin
        rng_hi_ff <= PWDATA[SMP_W-1:0];
      end
      if (PADDR[7:0] == OFS_IRQ_MASK[7:0]) begin
        irq_mask_ff <= PWDATA[IRQ_W-1:0];
      end
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      logic smp_hit;
      logic above;
      logic below;
      logic out_rng;
      logic wr_ch;

      assign smp_hit = SMP.valid && (32'(SMP.chan) == ch);
      assign above   = SMP.data > hi_lim_ff[ch];
      assign below   = SMP.data < lo_lim_ff[ch];
      assign out_rng = (SMP.data < rng_lo_ff) || (SMP.data > rng_hi_ff);
      assign wr_ch   = wr_en && is_chan && (32'(ch_idx) == ch);

      // Limits and modes each have their own word
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          hi_lim_ff[ch] <= RST_HI_LIM;
          lo_lim_ff[ch] <= RST_LO_LIM;
          cfg_ff[ch]    <= '0;
        end else if (wr_ch) begin
          if (ch_reg == CH_HI_LIM) begin
            hi_lim_ff[ch] <= PWDATA[SMP_W-1:0];
          end
          if (ch_reg == CH_LO_LIM) begin
            lo_lim_ff[ch] <= PWDATA[SMP_W-1:0];
          end
          if (ch_reg == CH_CFG) begin
            cfg_ff[ch] <= amm_cfg_t'(PWDATA[CFG_W-1:0]);
          end
        end
      end

      // Over-range samples are not valid values, so records skip them
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          max_ff[ch] <= CODE_LOW;
        end else if (rst_max[ch]) begin
          max_ff[ch] <= CODE_LOW;
        end else if (smp_hit && !out_rng && SMP.data > max_ff[ch]) begin
          max_ff[ch] <= SMP.data;
        end
      end

      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          min_ff[ch] <= CODE_HIGH;
        end else if (rst_min[ch]) begin
          min_ff[ch] <= CODE_HIGH;
        end else if (smp_hit && !out_rng && SMP.data < min_ff[ch]) begin
          min_ff[ch] <= SMP.data;
        end
      end

      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          cur_ff[ch] <= CODE_LOW;
          ovr_ff[ch] <= 1'b0;
        end else if (smp_hit) begin
          cur_ff[ch] <= SMP.data;
          ovr_ff[ch] <= out_rng;
        end
      end

      // High alarm; a new crossing beats a clear in the same cycle
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          alm_hi_ff[ch] <= 1'b0;
        end else begin
          unique case (cfg_ff[ch].hi_mode)
            AMM_LATCH: begin
              if (smp_hit && above) begin
                alm_hi_ff[ch] <= 1'b1;
              end else if (clr_hi[ch]) begin
                alm_hi_ff[ch] <= 1'b0;
              end
            end
            AMM_MOM: begin
              if (smp_hit) begin
                alm_hi_ff[ch] <= above;
              end
            end
            default: alm_hi_ff[ch] <= 1'b0;
          endcase
        end
      end

      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          alm_lo_ff[ch] <= 1'b0;
        end else begin
          unique case (cfg_ff[ch].lo_mode)
            AMM_LATCH: begin
              if (smp_hit && below) begin
                alm_lo_ff[ch] <= 1'b1;
              end else if (clr_lo[ch]) begin
                alm_lo_ff[ch] <= 1'b0;
              end
            end
            AMM_MOM: begin
              if (smp_hit) begin
                alm_lo_ff[ch] <= below;
              end
            end
            default: alm_lo_ff[ch] <= 1'b0;
          endcase
        end
      end

      assign ev_hi[ch]  = smp_hit && above && (cfg_ff[ch].hi_mode inside {AMM_LATCH, AMM_MOM});
      assign ev_lo[ch]  = smp_hit && below && (cfg_ff[ch].lo_mode inside {AMM_LATCH, AMM_MOM});
      assign ev_ovr[ch] = smp_hit && out_rng;
    end
  endgenerate

  // Output map; status already zero in disabled mode, so OR is safe
  genvar k;
  generate
    for (k = 0; k < NDO; k++) begin : g_do
      logic [NCH-1:0] hit_hi;
      logic [NCH-1:0] hit_lo;
      for (genvar c = 0; c < NCH; c++) begin : g_src
        assign hit_hi[c] = alm_hi_ff[c] && cfg_ff[c].hi_map_en && (32'(cfg_ff[c].hi_map) == k);
        assign hit_lo[c] = alm_lo_ff[c] && cfg_ff[c].lo_map_en && (32'(cfg_ff[c].lo_map) == k);
      end
      assign nxt_do[k] = |hit_hi || |hit_lo;
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      do_ff <= '0;
    end else begin
      do_ff <= nxt_do;
    end
  end

  // Sticky event flags, write one to clear, set wins
  always_comb begin
    irq_ev                          = '0;
    irq_ev[NCH-1:0]                 = ev_hi;
    irq_ev[FLD_LO+NCH-1:FLD_LO]     = ev_lo;
    irq_ev[FLD_OVR+NCH-1:FLD_OVR]   = ev_ovr;
    irq_clr                         = (wr_en && is_glob && PADDR[7:0] == OFS_IRQ_STAT[7:0]) ?
                                      PWDATA[IRQ_W-1:0] : '0;
    nxt_irq_stat                    = (irq_stat_ff & ~irq_clr) | irq_ev;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_stat_ff <= '0;
      irq_ff      <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff      <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  assign PRDATA  = prdata_ff;
  assign PREADY  = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign ALM_HI  = alm_hi_ff;
  assign ALM_LO  = alm_lo_ff;
  assign OVR     = ovr_ff;
  assign DO_OUT  = do_ff;
  assign IRQ     = irq_ff;

endmodule

// ### amm_chk.sv
`timescale 1ns/1ps
module amm_chk #(
  parameter int NCH = 8,
  parameter int NDO = 8
) (
  // Clock and reset
  input wire logic              CLK,
  input wire logic              RST_N,
  // Bus
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [31:0]       PRDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  // Samples and status
  input wire amm_pkg::amm_smp_t SMP,
  input wire logic [NCH-1:0]    ALM_HI,
  input wire logic [NCH-1:0]    ALM_LO,
  input wire logic [NCH-1:0]    OVR,
  input wire logic              IRQ
);
  import amm_pkg::*;
  logic wr_done;
  logic smp_v;
  // Status may only move one edge after a sample, or one or two edges after a write
  assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
  assign smp_v   = SMP.valid;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  chk_ready_wait: assert property ($rose(PENABLE) |-> !PREADY ##1 PREADY)
    else $error("ready not in second access cycle");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  chk_err_pulse: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
    else $error("error outside access answer");
  chk_err_rdata: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("refused read not zero");
  chk_hi_cause: assert property ($changed(ALM_HI) |-> $past(smp_v) || $past(wr_done) || $past(wr_done, 2))
    else $error("high status moved without cause");
  chk_lo_cause: assert property ($changed(ALM_LO) |-> $past(smp_v) || $past(wr_done) || $past(wr_done, 2))
    else $error("low status moved without cause");
  chk_ovr_cause: assert property ($changed(OVR) |-> $past(smp_v) || $past(wr_done))
    else $error("range flag moved without sample");
  chk_irq_rise: assert property ($rose(IRQ) |-> $past(smp_v) || $past(wr_done) || $past(wr_done, 2))
    else $error("interrupt rose without cause");
  chk_irq_fall: assert property ($fell(IRQ) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("interrupt fell without write");
endmodule

// ### amm_adc.sv
`timescale 1ns/1ps
module amm_adc (
  // Clock
  input wire logic          CLK,
  // Sample strobe
  output amm_pkg::amm_smp_t SMP
);
  import amm_pkg::*;
  initial SMP = '0;
  // Idle code is inverted so a stale value never looks valid
  task automatic send(input logic [2:0] ch, input amm_code_t d, input int gap);
    @(posedge CLK);
    SMP <= '{valid: 1'b1, chan: ch, data: d};
    @(posedge CLK);
    SMP <= '{valid: 1'b0, chan: ~ch, data: ~d};
    repeat (gap) @(posedge CLK);
  endtask
endmodule

// ### test_analog_input_alarm_minmax_monitor.sv
`timescale 1ns/1ps
`define CHK(n, x, g) begin cmp_count++; if ((g) !== (x)) begin fails++; $display("unexpected %s exp %0h got %0h", n, x, g); end end
module test_analog_input_alarm_minmax_monitor;
  import amm_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  alm_hi, alm_lo, ovr, do_out;
  amm_smp_t    smp;
  int          fails, cmp_count, cyc;

  amm_monitor #(.NCH(8), .NDO(8)) i_amm_monitor (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SMP(smp),
    .ALM_HI(alm_hi), .ALM_LO(alm_lo), .OVR(ovr), .DO_OUT(do_out), .IRQ(irq));
  amm_adc i_amm_adc (.CLK(clk), .SMP(smp));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  function automatic logic [11:0] ca(input int c, input logic [2:0] w);
    return 12'h100 + 12'(c) * 12'h020 + {7'h00, w, 2'h0};
  endfunction

  task automatic t_reset();
    rd(ca(0, CH_MAX));
    `CHK("max0", 32'h0, q)
    rd(ca(0, CH_MIN));
    `CHK("min0", 32'hffff, q)
    rd(ca(0, CH_HI_LIM));
    `CHK("hilim0", 32'hffff, q)
    rd(12'h300);
    `CHK("unmapped", 1'b1, e)
  endtask

  task automatic t_latch();
    wr(ca(1, CH_HI_LIM), 32'h1000);
    wr(ca(1, CH_CFG), 32'h01d);
    wr(OFS_IRQ_MASK, 32'h2);
    i_amm_adc.send(3'h1, 16'h1000, 3);
    `CHK("at_limit", 1'b0, alm_hi[1])
    i_amm_adc.send(3'h1, 16'h2000, 3);
    `CHK("hi1", 1'b1, alm_hi[1])
    `CHK("do3", 1'b1, do_out[3])
    `CHK("irq", 1'b1, irq)
    i_amm_adc.send(3'h1, 16'h0800, 3);
    `CHK("hi1_held", 1'b1, alm_hi[1])
    `CHK("do3_held", 1'b1, do_out[3])
    wr(OFS_LATCH_CLR, 32'h2);
    repeat (3) @(posedge clk);
    `CHK("hi1_clr", 1'b0, alm_hi[1])
    `CHK("do3_clr", 1'b0, do_out[3])
    wr(OFS_IRQ_STAT, 32'h2);
    repeat (2) @(posedge clk);
    `CHK("irq_clr", 1'b0, irq)
    // Low alarm in latched mode, cleared by its own bit
    wr(ca(1, CH_LO_LIM), 32'h0400);
    wr(ca(1, CH_CFG), 32'h05d);
    i_amm_adc.send(3'h1, 16'h0100, 3);
    `CHK("lo1", 1'b1, alm_lo[1])
    `CHK("hi1_quiet", 1'b0, alm_hi[1])
    i_amm_adc.send(3'h1, 16'h0800, 3);
    `CHK("lo1_held", 1'b1, alm_lo[1])
    wr(OFS_LATCH_CLR, 32'h200);
    repeat (2) @(posedge clk);
    `CHK("lo1_clr", 1'b0, alm_lo[1])
  endtask

  task automatic t_mom();
    wr(ca(2, CH_HI_LIM), 32'h8000);
    wr(ca(2, CH_LO_LIM), 32'h0100);
    // Both alarms momentary and onto output 5
    wr(ca(2, CH_CFG), 32'hbae);
    i_amm_adc.send(3'h2, 16'h0050, 3);
    `CHK("lo2", 1'b1, alm_lo[2])
    `CHK("hi2", 1'b0, alm_hi[2])
    `CHK("do5", 1'b1, do_out[5])
    i_amm_adc.send(3'h2, 16'h0200, 3);
    `CHK("lo2_gone", 1'b0, alm_lo[2])
    `CHK("do5_gone", 1'b0, do_out[5])
    i_amm_adc.send(3'h2, 16'h9000, 3);
    `CHK("hi2_set", 1'b1, alm_hi[2])
    `CHK("do5_or", 1'b1, do_out[5])
  endtask

  task automatic t_dis();
    wr(ca(3, CH_HI_LIM), 32'h0010);
    i_amm_adc.send(3'h3, 16'h0100, 3);
    `CHK("hi3", 1'b0, alm_hi[3])
    wr(ca(3, CH_CFG), 32'h007);
    i_amm_adc.send(3'h3, 16'h0100, 3);
    `CHK("do_mode3", 8'h20, do_out)
    rd(OFS_IRQ_STAT);
    `CHK("ev3", 1'b0, q[3])
  endtask

  task automatic t_rec();
    i_amm_adc.send(3'h4, 16'h0300, 0);
    i_amm_adc.send(3'h4, 16'h0500, 0);
    i_amm_adc.send(3'h4, 16'h0100, 0);
    i_amm_adc.send(3'h5, 16'h0700, 1);
    rd(ca(4, CH_MAX));
    `CHK("max4", 32'h0500, q)
    rd(ca(4, CH_MIN));
    `CHK("min4", 32'h0100, q)
    wr(OFS_REC_RST, 32'h10);
    rd(ca(4, CH_MAX));
    `CHK("max4_rst", 32'h0, q)
    rd(ca(5, CH_MAX));
    `CHK("max5_kept", 32'h0700, q)
    rd(ca(4, CH_MIN));
    `CHK("min4_kept", 32'h0100, q)
    wr(OFS_REC_RST, 32'h1000);
    rd(ca(4, CH_MIN));
    `CHK("min4_rst", 32'hffff, q)
  endtask

  task automatic t_ovr();
    wr(OFS_RNG_HI, 32'h0fff);
    i_amm_adc.send(3'h6, 16'h2000, 3);
    `CHK("ovr6", 1'b1, ovr[6])
    rd(ca(6, CH_CUR));
    `CHK("cur6", 32'h80002000, q)
    i_amm_adc.send(3'h6, 16'h0100, 3);
    `CHK("ovr6_gone", 1'b0, ovr[6])
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_latch();
    t_mom();
    t_dis();
    t_rec();
    t_ovr();
    tally_and_finish();
  end
endmodule

bind amm_monitor amm_chk #(.NCH(NCH), .NDO(NDO)) u_chk (
  .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .SMP(SMP), .ALM_HI(ALM_HI), .ALM_LO(ALM_LO), .OVR(OVR), .IRQ(IRQ));
